// ### src/apfs_bank.v
// analog/digital function select registers for ports a to d with read gating
//
// What this block does
// - a select bit of one makes the pin analog and blocks its digital read path.
// - a select bit of zero makes the pin digital and port reads return its sampled level.
// - select register bits with no pin behind them read as zero.
// - port b select holds all sixteen bits, read/write, reset to one.
// - port a select holds bits 10:9 and 7:6, read/write, reset to one, others unimplemented.
// - port c select holds bits 14:13 and 4, read/write, reset to one, others read zero.
// - port d select holds bits 7:6 only, read/write, reset to one, others read zero.
// - in the small package the port a select register is absent.
// - in the small package port c bit 4 is absent and reads zero.
// - a port read of an analog pin returns low whatever the pin voltage.
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ns
`include "apfs_regs.vh"
module apfs_bank #(
  parameter SMALL_PACKAGE = 0,
  parameter ADDR_WIDTH    = 4
) (
  // clock and reset
  input  wire                  clk_i,
  input  wire                  resetn_i,
  // register port
  input  wire [ADDR_WIDTH-1:0] addr_i,
  input  wire [15:0]           wdata_i,
  input  wire                  wr_i,
  input  wire                  rd_i,
  output reg  [15:0]           rdata_o,
  // raw pin levels from the pads
  input  wire [15:0]           pin_a_i,
  input  wire [15:0]           pin_b_i,
  input  wire [15:0]           pin_c_i,
  input  wire [15:0]           pin_d_i,
  // per pin analog selects to direction and read gating
  output reg  [15:0]           port_a_analog_select_o,
  output reg  [15:0]           port_b_analog_select_o,
  output reg  [15:0]           port_c_analog_select_o,
  output reg  [15:0]           port_d_analog_select_o,
  // gated digital levels for the port read path
  output reg  [15:0]           pin_a_level_o,
  output reg  [15:0]           pin_b_level_o,
  output reg  [15:0]           pin_c_level_o,
  output reg  [15:0]           pin_d_level_o
);

  // ==========================================================
  // implemented-bit masks
  // ==========================================================

  // package option strips port a and port c bit 4
  localparam [15:0] MASK_A = (SMALL_PACKAGE != 0) ? `APFS_MASK_A_SMALL : `APFS_MASK_A;
  localparam [15:0] MASK_B = `APFS_MASK_B;
  localparam [15:0] MASK_C = (SMALL_PACKAGE != 0) ? `APFS_MASK_C_SMALL : `APFS_MASK_C;
  localparam [15:0] MASK_D = `APFS_MASK_D;

  // address compare, shared by write and read decode
  function hit;
    input [ADDR_WIDTH-1:0] a;
    input [3:0]            off;
    begin
      hit = (a == {{(ADDR_WIDTH-4){1'b0}}, off});
    end
  endfunction

  // ==========================================================
  // select registers
  // ==========================================================

  wire [15:0] pin_a_sync;
  wire [15:0] pin_b_sync;
  wire [15:0] pin_c_sync;
  wire [15:0] pin_d_sync;

  // unimplemented bits are held at zero so they can never steer a pin
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      port_a_analog_select_o <= `APFS_RESET_ALL & MASK_A;
      port_b_analog_select_o <= `APFS_RESET_ALL & MASK_B;
      port_c_analog_select_o <= `APFS_RESET_ALL & MASK_C;
      port_d_analog_select_o <= `APFS_RESET_ALL & MASK_D;
    end else if (wr_i) begin
      if (hit(addr_i, `APFS_OFF_PORT_A)) begin
        port_a_analog_select_o <= wdata_i & MASK_A;
      end else if (hit(addr_i, `APFS_OFF_PORT_B)) begin
        port_b_analog_select_o <= wdata_i & MASK_B;
      end else if (hit(addr_i, `APFS_OFF_PORT_C)) begin
        port_c_analog_select_o <= wdata_i & MASK_C;
      end else if (hit(addr_i, `APFS_OFF_PORT_D)) begin
        port_d_analog_select_o <= wdata_i & MASK_D;
      end
    end
  end

  // ==========================================================
  // pin sampling and read gating
  // ==========================================================

  // pads are asynchronous to the system clock
  apfs_sync #(.WIDTH(16)) u_sync_a (.clk_i(clk_i), .resetn_i(resetn_i), .async_i(pin_a_i), .sync_o(pin_a_sync));
  apfs_sync #(.WIDTH(16)) u_sync_b (.clk_i(clk_i), .resetn_i(resetn_i), .async_i(pin_b_i), .sync_o(pin_b_sync));
  apfs_sync #(.WIDTH(16)) u_sync_c (.clk_i(clk_i), .resetn_i(resetn_i), .async_i(pin_c_i), .sync_o(pin_c_sync));
  apfs_sync #(.WIDTH(16)) u_sync_d (.clk_i(clk_i), .resetn_i(resetn_i), .async_i(pin_d_i), .sync_o(pin_d_sync));

  // gate with the stored select; software must wait a cycle after clearing one
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_a_level_o <= 16'h0000;
      pin_b_level_o <= 16'h0000;
      pin_c_level_o <= 16'h0000;
      pin_d_level_o <= 16'h0000;
    end else begin
      pin_a_level_o <= pin_a_sync & ~port_a_analog_select_o;
      pin_b_level_o <= pin_b_sync & ~port_b_analog_select_o;
      pin_c_level_o <= pin_c_sync & ~port_c_analog_select_o;
      pin_d_level_o <= pin_d_sync & ~port_d_analog_select_o;
    end
  end

  // ==========================================================
  // read port
  // ==========================================================

  // data stands only in the cycle after the strobe; unmapped reads return zero
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      if (hit(addr_i, `APFS_OFF_PORT_A)) begin
        rdata_o <= port_a_analog_select_o & MASK_A;
      end else if (hit(addr_i, `APFS_OFF_PORT_B)) begin
        rdata_o <= port_b_analog_select_o;
      end else if (hit(addr_i, `APFS_OFF_PORT_C)) begin
        rdata_o <= port_c_analog_select_o & MASK_C;
      end else if (hit(addr_i, `APFS_OFF_PORT_D)) begin
        rdata_o <= port_d_analog_select_o & MASK_D;
      end else if (hit(addr_i, `APFS_OFF_READ_A)) begin
        rdata_o <= pin_a_level_o;
      end else if (hit(addr_i, `APFS_OFF_READ_B)) begin
        rdata_o <= pin_b_level_o;
      end else if (hit(addr_i, `APFS_OFF_READ_C)) begin
        rdata_o <= pin_c_level_o;
      end else if (hit(addr_i, `APFS_OFF_READ_D)) begin
        rdata_o <= pin_d_level_o;
      end else begin
        rdata_o <= 16'h0000;
      end
    end else begin
      rdata_o <= 16'h0000;
    end
  end

endmodule

// ### src/apfs_regs.vh
// register offsets, implemented-bit masks and reset values of the analog select bank
`ifndef APFS_REGS_VH
`define APFS_REGS_VH

// word offsets on the register port
`define APFS_OFF_PORT_A      4'h0
`define APFS_OFF_PORT_B      4'h1
`define APFS_OFF_PORT_C      4'h2
`define APFS_OFF_PORT_D      4'h3
`define APFS_OFF_READ_A      4'h4
`define APFS_OFF_READ_B      4'h5
`define APFS_OFF_READ_C      4'h6
`define APFS_OFF_READ_D      4'h7

// implemented bits per register, full package
`define APFS_MASK_A          16'h06C0
`define APFS_MASK_B          16'hFFFF
`define APFS_MASK_C          16'h6010
`define APFS_MASK_D          16'h00C0

// implemented bits per register, small package
`define APFS_MASK_A_SMALL    16'h0000
`define APFS_MASK_C_SMALL    16'h6000

// reset value of every implemented bit: analog mode
`define APFS_RESET_ALL       16'hFFFF

`endif

// ### src/apfs_sync.v
// two-flop synchroniser for a bank of pin levels
`timescale 1ns/1ns
module apfs_sync #(
  parameter WIDTH = 16
) (
  // clock and reset
  input  wire             clk_i,
  input  wire             resetn_i,
  // levels
  input  wire [WIDTH-1:0] async_i,
  output reg  [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] stage;

  // first stage is read only by the second
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stage  <= {WIDTH{1'b0}};
      sync_o <= {WIDTH{1'b0}};
    end else begin
      stage  <= async_i;
      sync_o <= stage;
    end
  end

endmodule

// ### tb/apfs_bank_checker.sv
// assertion checker for the analog select bank
`timescale 1ns/1ns
`include "apfs_regs.vh"
module apfs_bank_checker #(parameter SMALL_PACKAGE = 0, parameter ADDR_WIDTH = 4) (
  // clock, reset and register port
  input wire                  clk_i, resetn_i, wr_i, rd_i,
  input wire [ADDR_WIDTH-1:0] addr_i,
  input wire [15:0]           wdata_i, rdata_o,
  // selects and gated level
  input wire [15:0]           port_a_analog_select_o, port_b_analog_select_o, port_c_analog_select_o, pin_b_level_o
);
  localparam [15:0] mask_a = SMALL_PACKAGE ? `APFS_MASK_A_SMALL : `APFS_MASK_A;
  localparam [15:0] mask_c = SMALL_PACKAGE ? `APFS_MASK_C_SMALL : `APFS_MASK_C;
  // ==========
  // one clock domain; a stale select would show up as a leak on the level path
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  a_port_a_mask: assert property ((port_a_analog_select_o & ~mask_a) == 16'h0000) else $error("a select off");
  a_port_c_mask: assert property ((port_c_analog_select_o & ~mask_c) == 16'h0000) else $error("c select off");
  a_write_b_lands: assert property (wr_i && addr_i == 1 |=> port_b_analog_select_o == $past(wdata_i))
    else $error("b write lost");
  a_write_c_lands: assert property (wr_i && addr_i == 2 |=> port_c_analog_select_o == ($past(wdata_i) & mask_c))
    else $error("c write lost");
  a_select_held: assert property (!wr_i |=> $stable(port_b_analog_select_o)) else $error("b select moved");
  a_read_echo: assert property (rd_i && addr_i == 0 |=> rdata_o == $past(port_a_analog_select_o))
    else $error("a read wrong");
  a_rdata_idle: assert property (!rd_i |=> rdata_o == 16'h0000) else $error("read data not idle");
  a_analog_blocks: assert property ((pin_b_level_o & $past(port_b_analog_select_o)) == 16'h0000)
    else $error("analog pin leaks");
endmodule
// every bank instance gets a checker with its own package setting
bind apfs_bank apfs_bank_checker #(.SMALL_PACKAGE(SMALL_PACKAGE), .ADDR_WIDTH(ADDR_WIDTH)) u_checker (
  .clk_i(clk_i), .resetn_i(resetn_i), .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
  .port_a_analog_select_o(port_a_analog_select_o), .port_b_analog_select_o(port_b_analog_select_o),
  .port_c_analog_select_o(port_c_analog_select_o), .pin_b_level_o(pin_b_level_o));

// ### tb/tb_apfs_bank.sv
// self-checking bench for the analog select bank
`timescale 1ns/1ns
`include "apfs_regs.vh"
module tb_apfs_bank;
  reg         clk_i = 1'b0, resetn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  reg  [3:0]  addr_i = 4'h0;
  reg  [15:0] wdata_i = 16'h0000, pin_b_i = 16'h0000;
  wire [15:0] rdata_o, sm_a, sm_c;
  integer     fail_count = 0, checked = 0, i;
  localparam [63:0] masks = {`APFS_MASK_D, `APFS_MASK_C, `APFS_MASK_B, `APFS_MASK_A};
  apfs_bank dut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .pin_a_i(pin_b_i), .pin_b_i(pin_b_i), .pin_c_i(pin_b_i), .pin_d_i(pin_b_i),
    .port_a_analog_select_o(), .port_b_analog_select_o(), .port_c_analog_select_o(), .port_d_analog_select_o(),
    .pin_a_level_o(), .pin_b_level_o(), .pin_c_level_o(), .pin_d_level_o());
  // small package variant shares the bus, so every write reaches both
  apfs_bank #(.SMALL_PACKAGE(1)) dut_small (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(), .pin_a_i(pin_b_i), .pin_b_i(pin_b_i), .pin_c_i(pin_b_i), .pin_d_i(pin_b_i),
    .port_a_analog_select_o(sm_a), .port_b_analog_select_o(), .port_c_analog_select_o(sm_c), .port_d_analog_select_o(),
    .pin_a_level_o(), .pin_b_level_o(), .pin_c_level_o(), .pin_d_level_o());
  // ==========
  // bus tasks; a write leaves its strobe up so writes run back to back
  task chk(input [15:0] got, input [15:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task results;
    if (fail_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task wr(input [3:0] a, input [15:0] d);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
  endtask
  task rd(input [3:0] a, input [15:0] e);
    wr_i   <= 1'b0;
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 chk(rdata_o, e);
    @(posedge clk_i);
  endtask
  // reset values, an unmapped read, and the small package
  task t_reset;
    for (i = 0; i < 4; i = i + 1) rd(i[3:0], masks[i*16 +: 16]);
    rd(4'h8, 16'h0000);
    chk(sm_a, 16'h0000);
    chk(sm_c, `APFS_MASK_C_SMALL);
  endtask
  // two writes then a read with no gap; unimplemented bits stay zero
  task t_write;
    for (i = 0; i < 4; i = i + 1) begin
      wr(i[3:0], 16'hFFFF);
      wr(i[3:0], 16'h5AA5);
      rd(i[3:0], masks[i*16 +: 16] & 16'h5AA5);
    end
    chk(sm_a, 16'h0000);
    chk(sm_c, 16'h4000);
  endtask
  // read-only place ignores writes; analog pins read low, digital pins pass
  task t_level;
    pin_b_i <= 16'hA5C3;
    wr(4'h5, 16'h0000);
    rd(4'h1, 16'h5AA5);
    for (i = 0; i < 3; i = i + 1) begin
      wr(4'h1, 16'hFFFF >> (i*8));
      rd(4'h1, 16'hFFFF >> (i*8));
      repeat (3) @(posedge clk_i);
      rd(4'h5, 16'hA5C3 & ~(16'hFFFF >> (i*8)));
    end
    // the other ports still hold the selects left by the write scenario
    rd(4'h4, 16'hA5C3 & ~(`APFS_MASK_A & 16'h5AA5));
    rd(4'h6, 16'hA5C3 & ~(`APFS_MASK_C & 16'h5AA5));
    rd(4'h7, 16'hA5C3 & ~(`APFS_MASK_D & 16'h5AA5));
  endtask
  initial forever #2 clk_i = ~clk_i;
  // the run needs about eighty cycles; this cuts a hang short
  initial begin
    repeat (2000) @(posedge clk_i);
    fail_count = fail_count + 1;
    results;
  end
  initial begin
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    t_reset;
    t_write;
    t_level;
    results;
  end
endmodule
